// *** chgst_defs.svh ***
// Overview of operation
// - Status registers sit at offsets 0x0, 0x1, 0x2; read-only.
// - Charger state bit 6 shows the taper phase.
// - Charger state bit 5 shows charge done.
// - Bits 4..1 show current limit, power-path, input-voltage, thermal regulation.
// - Bit 0 shows input power good: above both thresholds, below over-voltage.
// - Fault bit 7 shows input over-voltage, bit 5 battery over-current.
// - Fault bit 4 shows battery below its low threshold.
// - Fault bit 2 shows the cool thermistor region.
// - Fault bit 1 shows the warm thermistor region.
// - Comparator bits 6..4 show alarms one to three.
// - Comparator bit 0 shows open thermistor; bits 7 and 3..1 reserved.
// - Each condition has a flag that latches on entry (power good on any change), cleared by read.
// - The bus target address is 0x6B.
`ifndef CHGST_DEFS_SVH
`define CHGST_DEFS_SVH
`define CHGST_OFS_CHARGER 8'h00
`define CHGST_OFS_FAULT 8'h01
`define CHGST_OFS_COMP 8'h02
`define CHGST_OFS_FLAG_CHARGER 8'h03
`define CHGST_OFS_FLAG_FAULT 8'h04
`define CHGST_OFS_FLAG_COMP 8'h05
`define CHGST_TARGET_ADDR 7'h6b
`define CHGST_FLAG_RESET 8'h00
`define CHGST_MASK_CHARGER 8'h7f
`define CHGST_MASK_FAULT 8'hbf
`define CHGST_MASK_COMP 8'h71
`endif

// *** chgst_pkg.sv ***
package chgst_pkg;
   typedef struct packed {
      logic taper_phase_active;
      logic charge_done;
      logic input_current_limiting;
      logic power_path_regulating;
      logic input_voltage_regulating;
      logic thermal_regulating;
      logic input_above_uvlo;
      logic input_above_sleep;
      logic input_below_ovp;
      logic input_overvoltage;
      logic battery_overcurrent;
      logic battery_undervoltage;
      logic therm_cold_region;
      logic therm_cool_region;
      logic therm_warm_region;
      logic therm_hot_region;
      logic alarm_one_state;
      logic alarm_two_state;
      logic alarm_three_state;
      logic therm_open_state;
   } chgst_cond_type;
   typedef struct packed {
      logic valid;
      logic write;
      logic [6:0] target;
      logic [7:0] offset;
      logic [7:0] wdata;
   } chgst_req_type;
endpackage

// *** chgst_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module chgst_sync (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [19:0] async_i,
   output logic [19:0] sync_o
);
   logic [19:0] meta_q;
   logic [19:0] sync_q;
   genvar g;
   generate
      for (g = 0; g < 20; g++) begin : g_bit
         always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= async_i[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate
   assign sync_o = sync_q;
endmodule
`default_nettype wire

// *** chgst_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "chgst_defs.svh"
module chgst_regs (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire chgst_pkg::chgst_cond_type cond_i,
   input wire chgst_pkg::chgst_req_type req_i,
   output logic ack_o,
   output logic [7:0] rdata_o
);
   import chgst_pkg::*;
   chgst_cond_type cond_s;
   logic [7:0] st_chg, st_flt, st_cmp;
   logic [7:0] prev_chg_q, prev_chg_d, prev_flt_q, prev_flt_d, prev_cmp_q, prev_cmp_d;
   logic [7:0] flg_chg_q, flg_chg_d, flg_flt_q, flg_flt_d, flg_cmp_q, flg_cmp_d;
   logic [7:0] rdata_q, rdata_d;
   logic ack_q, ack_d, prim_q, prim_d;
   logic hit;

   chgst_sync u_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .async_i(cond_i),
      .sync_o(cond_s)
   );

   always_comb begin
      st_chg = {1'b0, cond_s.taper_phase_active,
         cond_s.charge_done,
         cond_s.input_current_limiting, cond_s.power_path_regulating,
         cond_s.input_voltage_regulating, cond_s.thermal_regulating,
         cond_s.input_above_uvlo & cond_s.input_above_sleep & cond_s.input_below_ovp};
      st_flt = {cond_s.input_overvoltage, 1'b0, cond_s.battery_overcurrent,
         cond_s.battery_undervoltage,
         cond_s.therm_cold_region,
         cond_s.therm_cool_region,
         cond_s.therm_warm_region,
         cond_s.therm_hot_region};
      st_cmp = {1'b0, cond_s.alarm_one_state, cond_s.alarm_two_state,
         cond_s.alarm_three_state, 3'b000, cond_s.therm_open_state};
   end

   assign hit = req_i.valid && (req_i.target == `CHGST_TARGET_ADDR);

   always_comb begin
      prev_chg_d = st_chg;
      prev_flt_d = st_flt;
      prev_cmp_d = st_cmp;
      prim_d = 1'b1;
      ack_d = hit;
      rdata_d = rdata_q;
      // Entry detect on most bits; power good flags any change
      flg_chg_d = flg_chg_q;
      flg_flt_d = flg_flt_q;
      flg_cmp_d = flg_cmp_q;
      if (hit && !req_i.write) begin
         unique case (req_i.offset)
            `CHGST_OFS_CHARGER: rdata_d = st_chg & `CHGST_MASK_CHARGER;
            `CHGST_OFS_FAULT: rdata_d = st_flt & `CHGST_MASK_FAULT;
            `CHGST_OFS_COMP: rdata_d = st_cmp & `CHGST_MASK_COMP;
            `CHGST_OFS_FLAG_CHARGER: begin
               rdata_d = flg_chg_q;
               flg_chg_d = `CHGST_FLAG_RESET;
            end
            `CHGST_OFS_FLAG_FAULT: begin
               rdata_d = flg_flt_q;
               flg_flt_d = `CHGST_FLAG_RESET;
            end
            `CHGST_OFS_FLAG_COMP: begin
               rdata_d = flg_cmp_q;
               flg_cmp_d = `CHGST_FLAG_RESET;
            end
            default: rdata_d = 8'h00;
         endcase
      end
      // Set wins over clear; no flags in the first cycle after reset
      if (prim_q) begin
         flg_chg_d = flg_chg_d | (st_chg & ~prev_chg_q & 8'h7e)
            | {7'h00, st_chg[0] ^ prev_chg_q[0]};
         flg_flt_d = flg_flt_d | (st_flt & ~prev_flt_q & `CHGST_MASK_FAULT);
         flg_cmp_d = flg_cmp_d | (st_cmp & ~prev_cmp_q & `CHGST_MASK_COMP);
      end
   end

   // Writes are acknowledged but never change state
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prev_chg_q <= 8'h00;
         prev_flt_q <= 8'h00;
         prev_cmp_q <= 8'h00;
         flg_chg_q <= `CHGST_FLAG_RESET;
         flg_flt_q <= `CHGST_FLAG_RESET;
         flg_cmp_q <= `CHGST_FLAG_RESET;
         rdata_q <= 8'h00;
         ack_q <= 1'b0;
         prim_q <= 1'b0;
      end else begin
         prev_chg_q <= prev_chg_d;
         prev_flt_q <= prev_flt_d;
         prev_cmp_q <= prev_cmp_d;
         flg_chg_q <= flg_chg_d;
         flg_flt_q <= flg_flt_d;
         flg_cmp_q <= flg_cmp_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         prim_q <= prim_d;
      end
   end

   assign ack_o = ack_q;
   assign rdata_o = rdata_q;

   property p_reserved_zero;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_COMP) |=> (rdata_o[7] == 1'b0
            && rdata_o[3:1] == 3'b000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_pgood;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_CHARGER) |=>
            rdata_o[0] == ($past(cond_s.input_above_uvlo) && $past(cond_s.input_above_sleep)
               && $past(cond_s.input_below_ovp));
   endproperty
   a_pgood: assert property (p_pgood) else $error("power good wrong");

   property p_taper;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_CHARGER) |=>
            rdata_o[7:6] == {1'b0, $past(cond_s.taper_phase_active)};
   endproperty
   a_taper: assert property (p_taper) else $error("taper bit wrong");

   property p_fault;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_FAULT) |=>
            rdata_o == ($past(st_flt) & 8'hbf);
   endproperty
   a_fault: assert property (p_fault) else $error("fault register wrong");

   property p_cold;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_FAULT) |=>
            rdata_o[3] == $past(cond_s.therm_cold_region);
   endproperty
   a_cold: assert property (p_cold) else $error("cold bit wrong");

   property p_alarm;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_COMP) |=>
            rdata_o[6:4] == {$past(cond_s.alarm_one_state), $past(cond_s.alarm_two_state),
               $past(cond_s.alarm_three_state)};
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm bits wrong");

   property p_write_none;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && req_i.write) |=> rdata_o == $past(rdata_o);
   endproperty
   a_write_none: assert property (p_write_none) else $error("write changed data");

   property p_flag_set;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (prim_q && st_flt[3] && !prev_flt_q[3]) |=> flg_flt_q[3];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not latched");

   property p_addr;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (req_i.valid && req_i.target != `CHGST_TARGET_ADDR) |=> !ack_o;
   endproperty
   a_addr: assert property (p_addr) else $error("wrong target answered");

   property p_ack;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         hit |=> ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("own target not answered");

   property p_done;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_CHARGER) |=>
            rdata_o[5] == $past(cond_s.charge_done);
   endproperty
   a_done: assert property (p_done) else $error("done bit wrong");

   property p_regulating;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_CHARGER) |=>
            rdata_o[4:1] == {$past(cond_s.input_current_limiting),
               $past(cond_s.power_path_regulating), $past(cond_s.input_voltage_regulating),
               $past(cond_s.thermal_regulating)};
   endproperty
   a_regulating: assert property (p_regulating) else $error("regulation bits wrong");

   property p_battery_low;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_FAULT) |=>
            rdata_o[4] == $past(cond_s.battery_undervoltage);
   endproperty
   a_battery_low: assert property (p_battery_low) else $error("battery low bit wrong");

   property p_cool;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_FAULT) |=>
            rdata_o[2] == $past(cond_s.therm_cool_region);
   endproperty
   a_cool: assert property (p_cool) else $error("cool bit wrong");

   property p_warm;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_FAULT) |=>
            rdata_o[1] == $past(cond_s.therm_warm_region);
   endproperty
   a_warm: assert property (p_warm) else $error("warm bit wrong");

   property p_hot;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_FAULT) |=>
            rdata_o[0] == $past(cond_s.therm_hot_region);
   endproperty
   a_hot: assert property (p_hot) else $error("hot bit wrong");

   property p_open;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_COMP) |=>
            rdata_o[0] == $past(cond_s.therm_open_state);
   endproperty
   a_open: assert property (p_open) else $error("open bit wrong");

   property p_unmapped;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset > `CHGST_OFS_FLAG_COMP) |=> rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped offset not zero");

   property p_flag_clear;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (hit && !req_i.write && req_i.offset == `CHGST_OFS_FLAG_FAULT
            && !(prim_q && |(st_flt & ~prev_flt_q & `CHGST_MASK_FAULT)))
            |=> flg_flt_q == 8'h00;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   property p_pgood_flag;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         (prim_q && (st_chg[0] != prev_chg_q[0])) |=> flg_chg_q[0];
   endproperty
   a_pgood_flag: assert property (p_pgood_flag) else $error("power good change missed");

   c_read_chg: cover property (@(posedge core_clk_i)
      hit && !req_i.write && req_i.offset == `CHGST_OFS_CHARGER);
   c_read_flag: cover property (@(posedge core_clk_i)
      hit && !req_i.write && req_i.offset == `CHGST_OFS_FLAG_FAULT && flg_flt_q != 8'h00);
   c_write: cover property (@(posedge core_clk_i) hit && req_i.write);
endmodule
`default_nettype wire

// *** chgst_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module chgst_host (
   input wire logic core_clk_i,
   input wire logic ack_i,
   input wire logic [7:0] rdata_i,
   output var chgst_pkg::chgst_req_type req_o
);
   import chgst_pkg::*;
   initial req_o = '0;
   // One byte access; request stands for one edge, answer taken at the next rising edge
   task automatic xfer(input logic [6:0] tgt, input logic wr, input logic [7:0] ofs,
      input logic [7:0] wd, output logic ack, output logic [7:0] rd);
      chgst_req_type r;
      r = '{1'b1, wr, tgt, ofs, wd};
      @(posedge core_clk_i) req_o <= r;
      @(posedge core_clk_i) req_o <= '0;
      @(posedge core_clk_i);
      ack = ack_i;
      rd = rdata_i;
   endtask
endmodule
`default_nettype wire

// *** charger_status_registers_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module charger_status_registers_test;
   import chgst_pkg::*;
   typedef struct packed {
      chgst_cond_type cond;
      logic [23:0] exp;
   } chgst_row_type;
   logic core_clk_i, reset_n_i, ack, ack_o;
   logic [7:0] rd, rdata_o;
   chgst_cond_type cond_i;
   chgst_req_type req_i;
   chgst_row_type rows [22];
   int miscompares, total_checks;
   chgst_regs uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cond_i(cond_i),
      .req_i(req_i), .ack_o(ack_o), .rdata_o(rdata_o));
   chgst_host host (.core_clk_i(core_clk_i), .ack_i(ack_o), .rdata_i(rdata_o), .req_o(req_i));
   function automatic logic [23:0] expect_of(chgst_cond_type c);
      return {1'b0, c.taper_phase_active, c.charge_done, c.input_current_limiting,
         c.power_path_regulating, c.input_voltage_regulating, c.thermal_regulating,
         c.input_above_uvlo & c.input_above_sleep & c.input_below_ovp,
         c.input_overvoltage, 1'b0, c.battery_overcurrent, c.battery_undervoltage,
         c.therm_cold_region, c.therm_cool_region, c.therm_warm_region,
         c.therm_hot_region, 1'b0, c.alarm_one_state, c.alarm_two_state,
         c.alarm_three_state, 3'h0, c.therm_open_state};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
      host.xfer(7'h6b, 1'b0, ofs, 8'h00, ack, rd);
      chk({7'h0, ack}, 8'h01);
      chk(rd, exp);
   endtask
   task automatic settle(input chgst_cond_type c);
      @(posedge core_clk_i) cond_i <= c;
      repeat (3) @(posedge core_clk_i);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   initial begin
      repeat (5000) @(posedge core_clk_i);
      miscompares++;
      test_done();
   end
   initial begin
      reset_n_i = 1'b0;
      cond_i = '0;
      repeat (12) @(posedge core_clk_i);
      chk({7'h0, ack_o}, 8'h00);
      chk(rdata_o, 8'h00);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 22; i++) begin
         rows[i].cond = (i < 20) ? 20'h1 << i : ((i == 20) ? 20'hfffff : 20'h03800);
         rows[i].exp = expect_of(rows[i].cond);
      end
      foreach (rows[i]) begin
         settle(rows[i].cond);
         for (int k = 0; k < 3; k++) begin
            rd_chk(8'(k), rows[i].exp[23 - 8 * k -: 8]);
         end
      end
      // Writes acknowledged but ignored
      host.xfer(7'h6b, 1'b1, 8'h00, 8'hfe, ack, rd);
      chk({7'h0, ack}, 8'h01);
      @(posedge core_clk_i);
      chk({7'h0, ack_o}, 8'h00);
      host.xfer(7'h6b, 1'b1, 8'h01, 8'hff, ack, rd);
      rd_chk(8'h00, 8'h01);
      rd_chk(8'h01, 8'h00);
      // Foreign target gets no answer
      host.xfer(7'h6a, 1'b0, 8'h00, 8'h00, ack, rd);
      chk({7'h0, ack}, 8'h00);
      rd_chk(8'h06, 8'h00);
      rd_chk(8'hff, 8'h00);
      // Flags latch on entry and clear when read
      settle('0);
      for (int k = 3; k < 6; k++) begin
         host.xfer(7'h6b, 1'b0, 8'(k), 8'h00, ack, rd);
      end
      settle(20'h80018);
      rd_chk(8'h03, 8'h40);
      rd_chk(8'h04, 8'h01);
      rd_chk(8'h05, 8'h40);
      for (int k = 3; k < 6; k++) begin
         rd_chk(8'(k), 8'h00);
      end
      settle('0);
      rd_chk(8'h03, 8'h00);
      // Mid-run reset drops pending flags
      settle(20'h80018);
      rd_chk(8'h00, 8'h40);
      @(posedge core_clk_i) reset_n_i <= 1'b0;
      cond_i <= '0;
      repeat (2) @(posedge core_clk_i);
      chk({7'h0, ack_o}, 8'h00);
      chk(rdata_o, 8'h00);
      reset_n_i <= 1'b1;
      for (int k = 3; k < 6; k++) begin
         rd_chk(8'(k), 8'h00);
      end
      test_done();
   end
endmodule
`default_nettype wire
